// >>> sim/iam_flags_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module iam_flags_tb_top;
  localparam logic [7:0] CT = iam_pkg::A_CTRL;
  localparam logic [7:0] ST = iam_pkg::A_STAT;
  localparam logic [7:0] SH = iam_pkg::A_SHIFT;
  localparam logic [7:0] MK = iam_pkg::A_IMASK;
  logic clk_i;
  logic rstn_i;
  logic mst;
  logic ald;
  logic sg;
  logic ext;
  logic rd_q = 1'b0;
  logic [7:0] rdata;
  logic [6:0] own;
  logic [7:0] d;
  logic scl;
  logic p_sda;
  logic sda_o;
  logic oe;
  logic wrel;
  logic match;
  logic trc;
  logic irq;
  wire logic sda;
  iam_pkg::iam_bus_s bus;
  logic [7:0] exp_q[$];
  int n_errors;
  int checks;
  int n_wrel = 0;
  // Open drain with pull-up: any party may pull the line low
  assign sda = p_sda & ~(oe & ~sda_o);
  iam_peer u_peer (.scl_o(scl), .sda_o(p_sda));
  iam_flags u_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .bus_i(bus), .rdata_o(rdata),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(oe),
    .master_state_i(mst), .arb_lost_i(ald), .ext_code_i(ext),
    .start_gen_i(sg), .wait_rel_o(wrel), .match_o(match), .trc_o(trc),
    .irq_o(irq)
  );
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    rd_q <= bus.rd;
    if (wrel === 1'b1) n_wrel <= n_wrel + 1;
  end
  // Read data stands only in the cycle after the strobe
  always @(negedge clk_i) begin
    if (rd_q === 1'b1) chk_rd(rdata, exp_q.pop_front());
  end
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t read got %h exp %h", $time, got, exp);
    end
  endtask : chk_rd
  task automatic chk(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge clk_i);
    bus.wr <= 1'b0;
    @(negedge clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    exp_q.push_back(v);
    @(posedge clk_i);
    bus.rd <= 1'b0;
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wt
  task automatic addr(input logic [6:0] a, input logic dir);
    u_peer.start_c();
    u_peer.put_byte({a, dir});
    wt(8);
  endtask : addr
  task automatic close_out();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  initial begin
    #200000;
    n_errors++;
    $display("[ERR] %0t timeout", $time);
    close_out();
  end
  initial begin
    clk_i = 1'b0;
    rstn_i = 1'b0;
    bus = '0;
    mst = 1'b0;
    ald = 1'b0;
    sg = 1'b0;
    ext = 1'b0;
    n_errors = 0;
    checks = 0;
    void'($urandom(43));
    own = 7'($urandom());
    d = 8'($urandom());
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(ST, 8'h00);
    rd(8'hFC, 8'h00);
    wr(iam_pkg::A_OWN, {own, 1'b0});
    wr(MK, 8'h01);
    wr(CT, 8'h80);
    rd(MK, 8'h01);
    addr(own, 1'b1);
    chk(match, 1'b1);
    chk(trc, 1'b1);
    chk(irq, 1'b1);
    rd(ST, 8'h18);
    wr(SH, d);
    wt(4);
    chk(oe, ~d[7]);
    chk(n_wrel == 1, 1'b1);
    wr(CT, 8'hA0);
    wt(4);
    chk(trc, 1'b0);
    chk(oe, 1'b0);
    wr(MK, 8'h00);
    chk(irq, 1'b0);
    wr(MK, 8'h01);
    chk(irq, 1'b1);
    wr(iam_pkg::A_ISTAT, 8'h07);
    chk(irq, 1'b0);
    u_peer.stop_c();
    wt(8);
    chk(match, 1'b0);
    addr(own ^ 7'h01, 1'b1);
    chk(match, 1'b0);
    chk(trc, 1'b0);
    u_peer.stop_c();
    // Repeated start while transmitting, latch MSB high keeps line free
    addr(own, 1'b1);
    wr(SH, 8'h80);
    u_peer.start_c();
    wt(8);
    chk(trc, 1'b0);
    chk(match, 1'b0);
    u_peer.put_byte({own, 1'b1});
    wt(8);
    chk(trc, 1'b1);
    wr(CT, 8'hC0);
    wt(4);
    chk(match, 1'b0);
    chk(trc, 1'b0);
    u_peer.stop_c();
    for (int j = 0; j < 2; j++) begin
      addr(own, j[0]);
      chk(trc, j[0]);
      if (j == 0) chk(oe, 1'b0);
      wr(CT, 8'h00);
      wt(4);
      chk(match, 1'b0);
      chk(trc, 1'b0);
      wr(CT, 8'h80);
      u_peer.stop_c();
    end
    // Master: start generated, then the peer clocks the address byte
    for (int j = 0; j < 2; j++) begin
      @(posedge clk_i);
      mst <= 1'b1;
      sg <= 1'b1;
      @(posedge clk_i);
      sg <= 1'b0;
      wt(2);
      chk(trc, 1'b1);
      u_peer.start_c();
      u_peer.put_byte({own ^ 7'h01, j[0]});
      wt(8);
      chk(trc, ~j[0]);
      @(posedge clk_i);
      ald <= 1'b1;
      wt(4);
      chk(trc, 1'b0);
      @(posedge clk_i);
      ald <= 1'b0;
      mst <= 1'b0;
      u_peer.stop_c();
    end
    // Reset in the middle of a slave transmit drops both flags
    addr(own, 1'b1);
    chk(match, 1'b1);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    wt(2);
    chk(match, 1'b0);
    chk(trc, 1'b0);
    @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(ST, 8'h00);
    u_peer.stop_c();
    wr(CT, 8'h80);
    // Extension flag alone keeps the device in communication
    @(posedge clk_i);
    mst <= 1'b1;
    sg <= 1'b1;
    ext <= 1'b1;
    @(posedge clk_i);
    sg <= 1'b0;
    mst <= 1'b0;
    wt(4);
    chk(trc, 1'b1);
    rd(ST, 8'h28);
    ext <= 1'b0;
    wt(4);
    chk(trc, 1'b0);
    wt(10);
    close_out();
  end
endmodule : iam_flags_tb_top
`default_nettype wire

// >>> sim/iam_peer.sv
`timescale 1ns/1ps
`default_nettype none
module iam_peer (
  output logic scl_o,
  output logic sda_o
);
  // Quarter of the 160 ns link period; clock idles high outside frames
  localparam int Q = 40;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Also serves as a repeated start from a stalled low clock
  task automatic start_c();
    sda_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b0;
    #Q;
  endtask : start_c
  task automatic stop_c();
    sda_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b1;
    #Q;
  endtask : stop_c
  // MSB first, direction in bit 0, line released for the ack slot
  task automatic put_byte(input logic [7:0] b);
    for (int i = 8; i >= 0; i--) begin
      sda_o = (i == 0) ? 1'b1 : b[i-1];
      #Q scl_o = 1'b1;
      #(2*Q) scl_o = 1'b0;
      #Q;
    end
  endtask : put_byte
endmodule : iam_peer
`default_nettype wire

// >>> src/iam_flags.sv
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module iam_flags (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire iam_pkg::iam_bus_s bus_i,
  output logic [7:0] rdata_o,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic master_state_i,
  input wire logic arb_lost_i,
  input wire logic ext_code_i,
  input wire logic start_gen_i,
  output logic wait_rel_o,
  output logic match_o,
  output logic trc_o,
  output logic irq_o
);

  iam_pkg::iam_st_s s_ff;
  iam_pkg::iam_st_s nxt_s;

  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic addr_hit;
  logic match;
  logic dir;
  logic exit_w;
  logic wrel_w;
  logic shift_w;
  logic ninth;
  logic [7:0] abyte;
  logic [7:0] stat;
  logic [2:0] ev;

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_s = s_ff;
    // Edges are seen only on the second synchroniser stage
    rise = s_ff.scl_s & ~s_ff.scl_d;
    fall = ~s_ff.scl_s & s_ff.scl_d;
    start = s_ff.scl_s & s_ff.scl_d & ~s_ff.sda_s & s_ff.sda_d & s_ff.en;
    stop = s_ff.scl_s & s_ff.scl_d & s_ff.sda_s & ~s_ff.sda_d & s_ff.en;
    abyte = {s_ff.rx[6:0], s_ff.sda_s};
    match = abyte[7:1] == s_ff.own;
    dir = abyte[0];
    addr_hit = rise & s_ff.first & (s_ff.cnt == iam_pkg::CNT_SEVEN) & s_ff.en;
    ninth = s_ff.cnt == iam_pkg::CNT_NINTH;
    exit_w = 1'b0;
    wrel_w = 1'b0;
    shift_w = bus_i.wr & (bus_i.addr == iam_pkg::A_SHIFT);
    stat = {master_state_i, arb_lost_i, ext_code_i, s_ff.coi, s_ff.trc,
            3'h0};

    nxt_s.scl_m = scl_i;
    nxt_s.scl_s = s_ff.scl_m;
    nxt_s.scl_d = s_ff.scl_s;
    nxt_s.sda_m = sda_i;
    nxt_s.sda_s = s_ff.sda_m;
    nxt_s.sda_d = s_ff.sda_s;
    nxt_s.ald_d = arb_lost_i;

    // Register writes; exit and wait release are one-shot commands
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        iam_pkg::A_CTRL: begin
          nxt_s.en = bus_i.wdata[iam_pkg::C_EN];
          exit_w = bus_i.wdata[iam_pkg::C_EXIT];
          wrel_w = bus_i.wdata[iam_pkg::C_WREL];
        end
        iam_pkg::A_OWN: begin
          nxt_s.own = bus_i.wdata[7:1];
        end
        iam_pkg::A_IMASK: begin
          nxt_s.imask = bus_i.wdata[2:0];
        end
        default: begin
        end
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Byte framing on the serial link
    if (rise) begin
      nxt_s.rx = abyte;
      nxt_s.cnt = ninth ? iam_pkg::CNT_ONE : s_ff.cnt + iam_pkg::CNT_ONE;
    end
    if (fall) begin
      if (s_ff.cnt == iam_pkg::CNT_ADDR) begin
        nxt_s.ack = 1'b1;
      end
      if (ninth) begin
        nxt_s.ack = 1'b0;
        if (s_ff.first) begin
          nxt_s.first = 1'b0;
          nxt_s.drv = 1'b1;
        end
      end
      if ((s_ff.cnt >= iam_pkg::CNT_ONE) && (s_ff.cnt <= iam_pkg::CNT_SEVEN))
      begin
        nxt_s.tx = {s_ff.tx[6:0], 1'b1};
      end
    end
    if (start) begin
      nxt_s.cnt = iam_pkg::CNT_ZERO;
      nxt_s.first = 1'b1;
      nxt_s.drv = 1'b0;
      nxt_s.ack = 1'b0;
    end
    if (stop) begin
      nxt_s.cnt = iam_pkg::CNT_ZERO;
      nxt_s.first = 1'b0;
      nxt_s.drv = 1'b0;
      nxt_s.ack = 1'b0;
    end
    // A late write beats the shifter so the new byte is never lost
    if (shift_w) begin
      nxt_s.tx = bus_i.wdata;
    end

    //////////////////////////////////////////////////////////////////////////
    // Address match flag: clears first, the set wins over them
    if (start | stop) begin
      nxt_s.coi = 1'b0;
    end
    if (exit_w) begin
      nxt_s.coi = 1'b0;
    end
    if (addr_hit & match) begin
      nxt_s.coi = 1'b1;
    end

    // Direction flag
    if (start & ~master_state_i) begin
      nxt_s.trc = 1'b0;
    end
    if (arb_lost_i & ~s_ff.ald_d) begin
      nxt_s.trc = 1'b0;
    end
    if (~master_state_i & ~ext_code_i & ~s_ff.coi) begin
      nxt_s.trc = 1'b0;
    end
    if (wrel_w & s_ff.trc & ninth) begin
      nxt_s.trc = 1'b0;
      nxt_s.drv = 1'b0;
    end
    if (exit_w) begin
      nxt_s.trc = 1'b0;
    end
    if (addr_hit & master_state_i) begin
      nxt_s.trc = ~dir;
    end
    if (addr_hit & ~master_state_i & match & dir) begin
      nxt_s.trc = 1'b1;
    end
    if (start_gen_i) begin
      nxt_s.trc = 1'b1;
    end

    // Stopping the bus drops the flags and byte framing; tx and istat keep their values, rx still shifts on each scl rise
    if (~nxt_s.en) begin
      nxt_s.coi = 1'b0;
      nxt_s.trc = 1'b0;
      nxt_s.first = 1'b0;
      nxt_s.drv = 1'b0;
      nxt_s.ack = 1'b0;
      nxt_s.cnt = iam_pkg::CNT_ZERO;
    end

    // Open drain: pull low only for a zero bit, never in the ack slot
    nxt_s.sda_oe = nxt_s.trc & nxt_s.drv & ~nxt_s.ack
                   & ~nxt_s.tx[7];

    // Either command frees the clock; the shift write is the normal path
    nxt_s.wrel_p = wrel_w | shift_w;

    //////////////////////////////////////////////////////////////////////////
    ev = 3'h0;
    ev[iam_pkg::I_MATCH] = addr_hit & match;
    ev[iam_pkg::I_START] = start;
    ev[iam_pkg::I_STOP] = stop;
    if (bus_i.wr & (bus_i.addr == iam_pkg::A_ISTAT)) begin
      nxt_s.istat = s_ff.istat & ~bus_i.wdata[2:0];
    end
    nxt_s.istat = nxt_s.istat | ev;

    nxt_s.rdata = iam_pkg::RST_BYTE;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        iam_pkg::A_CTRL: nxt_s.rdata = {s_ff.en, 7'h00};
        iam_pkg::A_STAT: nxt_s.rdata = stat;
        iam_pkg::A_OWN: nxt_s.rdata = {s_ff.own, 1'b0};
        iam_pkg::A_SHIFT: nxt_s.rdata = s_ff.rx;
        iam_pkg::A_ISTAT: nxt_s.rdata = {5'h00, s_ff.istat};
        iam_pkg::A_IMASK: nxt_s.rdata = {5'h00, s_ff.imask};
        default: nxt_s.rdata = iam_pkg::RST_BYTE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_ff <= '{scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1,
                sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1,
                en: 1'b0, own: iam_pkg::RST_OWN,
                tx: iam_pkg::RST_BYTE, rx: iam_pkg::RST_BYTE,
                cnt: iam_pkg::CNT_ZERO, first: 1'b0, drv: 1'b0,
                ack: 1'b0, coi: 1'b0, trc: 1'b0, ald_d: 1'b0,
                sda_oe: 1'b0, wrel_p: 1'b0,
                rdata: iam_pkg::RST_BYTE,
                istat: iam_pkg::RST_IRQ, imask: iam_pkg::RST_IRQ};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rdata_o = s_ff.rdata;
  assign sda_o = 1'b0;
  assign sda_oe_o = s_ff.sda_oe;
  assign wait_rel_o = s_ff.wrel_p;
  assign match_o = s_ff.coi;
  assign trc_o = s_ff.trc;
  assign irq_o = |(s_ff.istat & s_ff.imask);

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence seq_hit;
    addr_hit && match && s_ff.en && !bus_i.wr;
  endsequence

  sequence seq_wrel_ninth;
    wrel_w && s_ff.trc && ninth && !start_gen_i && nxt_s.en;
  endsequence

  AST_COI_SET: assert property (seq_hit |=> s_ff.coi)
    else $error("match flag not set on address hit");

  AST_COI_CLR: assert property (
    (start || stop) && !addr_hit |=> !s_ff.coi)
    else $error("match flag survived start or stop");

  AST_EXIT: assert property (
    exit_w && !addr_hit && !start_gen_i |=> !s_ff.coi && !s_ff.trc)
    else $error("exit did not clear flags");

  AST_EN_OFF: assert property (
    s_ff.en && !nxt_s.en |=> !s_ff.coi && !s_ff.trc ##1 !s_ff.sda_oe)
    else $error("disable did not clear flags");

  AST_FLOAT: assert property (!s_ff.trc |-> !sda_oe_o)
    else $error("data line driven while receiving");

  AST_DRIVE: assert property (
    s_ff.trc && s_ff.drv && !s_ff.ack && !s_ff.tx[7] |-> sda_oe_o)
    else $error("zero bit not driven while transmitting");

  AST_NO_DRV: assert property (!s_ff.drv |-> !sda_oe_o)
    else $error("data line driven before first ninth fall");

  AST_ACK_FREE: assert property (s_ff.ack |-> !sda_oe_o)
    else $error("data line driven in the ack slot");

  AST_MST_SET: assert property (start_gen_i && nxt_s.en |=> s_ff.trc)
    else $error("direction not set on generated start");

  AST_MST_CLR: assert property (
    addr_hit && master_state_i && dir && !start_gen_i |=> !s_ff.trc)
    else $error("master read did not clear direction");

  AST_SLV_SET: assert property (
    seq_hit ##0 (!master_state_i && dir) |=> s_ff.trc && s_ff.coi)
    else $error("slave transmit not entered");

  AST_SLV_START: assert property (
    start && !master_state_i && !start_gen_i |=> !s_ff.trc)
    else $error("slave direction survived start");

  AST_ALD: assert property (
    $rose(arb_lost_i) && !start_gen_i |=> !s_ff.trc)
    else $error("direction survived arbitration loss");

  AST_IDLE: assert property (
    !master_state_i && !ext_code_i && !s_ff.coi && !start_gen_i
    && !(addr_hit && match) |=> !s_ff.trc)
    else $error("direction kept while not communicating");

  AST_WREL: assert property (
    seq_wrel_ninth |=> wait_rel_o && !s_ff.trc && !sda_oe_o)
    else $error("wait release in ninth clock mishandled");

  AST_SHIFT_REL: assert property (shift_w |=> wait_rel_o)
    else $error("shift write did not release the wait");

  AST_IRQ_HIT: assert property (
    seq_hit |=> s_ff.istat[iam_pkg::I_MATCH])
    else $error("address hit not latched in interrupt status");

endmodule : iam_flags
`default_nettype wire

// >>> src/iam_pkg.sv
package iam_pkg;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_OWN = 8'h08;
  localparam logic [7:0] A_SHIFT = 8'h0C;
  localparam logic [7:0] A_ISTAT = 8'h10;
  localparam logic [7:0] A_IMASK = 8'h14;
  localparam int unsigned C_EN = 7;
  localparam int unsigned C_EXIT = 6;
  localparam int unsigned C_WREL = 5;
  localparam int unsigned S_MSTS = 7;
  localparam int unsigned S_ALD = 6;
  localparam int unsigned S_EXC = 5;
  localparam int unsigned S_COI = 4;
  localparam int unsigned S_TRC = 3;
  localparam int unsigned I_MATCH = 0;
  localparam int unsigned I_START = 1;
  localparam int unsigned I_STOP = 2;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_SEVEN = 4'h7;
  localparam logic [3:0] CNT_ADDR = 4'h8;
  localparam logic [3:0] CNT_NINTH = 4'h9;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] RST_OWN = 7'h00;
  localparam logic [2:0] RST_IRQ = 3'h0;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } iam_bus_s;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic en;
    logic [6:0] own;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [3:0] cnt;
    logic first;
    logic drv;
    logic ack;
    logic coi;
    logic trc;
    logic ald_d;
    logic sda_oe;
    logic wrel_p;
    logic [7:0] rdata;
    logic [2:0] istat;
    logic [2:0] imask;
  } iam_st_s;
endpackage : iam_pkg
